// ### design/acm_pkg.sv
package acm_pkg;
    // Widths and counts
    localparam int ENGINES = 2;
    localparam int CMD_W = 32;
    localparam int REG_W = 16;
    localparam int RES_W = 14;
    localparam int RAW_W = 12;
    localparam int RAW_SHIFT = 2;
    localparam int GAIN_W = 15;
    localparam int GAIN_FRAC = 14;
    localparam int OFFSET_W = 14;
    localparam int PROD_W = RES_W + GAIN_W;
    localparam int SUM_W = 17;
    localparam int TAG_W = 4;
    localparam int CHAN_W = 8;

    // Command word fields
    localparam int CMD_SEL_BIT = 25;
    localparam int CMD_CAL_BIT = 24;
    localparam int CMD_RD_BIT = 24;
    localparam int CMD_TAG_LSB = 20;
    localparam int CMD_LST_LSB = 18;
    localparam int CMD_CHAN_LSB = 8;
    localparam int CMD_VAL_LSB = 8;

    // Engine internal register addresses
    localparam logic [7:0] ADDR_CONV = 8'h00;
    localparam logic [7:0] ADDR_CTRL = 8'h01;
    localparam logic [7:0] ADDR_TSTAMP = 8'h02;
    localparam logic [7:0] ADDR_TBASE = 8'h03;
    localparam logic [7:0] ADDR_GAIN = 8'h04;
    localparam logic [7:0] ADDR_OFFSET = 8'h05;

    // Reference channels and their sample-time codes
    localparam logic [7:0] CHAN_HIGH_REF = 8'h2b;
    localparam logic [7:0] CHAN_LOW_REF = 8'h2c;
    localparam logic [1:0] LST_HIGH_REF = 2'b00;
    localparam logic [1:0] LST_LOW_REF = 2'b10;
    localparam logic [7:0] SAMP_CYC_0 = 8'h02;
    localparam logic [7:0] SAMP_CYC_1 = 8'h08;
    localparam logic [7:0] SAMP_CYC_2 = 8'h40;
    localparam logic [7:0] SAMP_CYC_3 = 8'h80;
    localparam logic [1:0] REF_SEL_NONE = 2'b00;
    localparam logic [1:0] REF_SEL_HIGH = 2'b01;
    localparam logic [1:0] REF_SEL_LOW = 2'b10;

    // MAC constants and reset values
    localparam logic signed [16:0] HALF_LSB_ADJ = 17'sh00002;
    localparam logic signed [16:0] RES_MAX = 17'sh03fff;
    localparam logic [14:0] GAIN_RESET = 15'h4000;
    localparam logic [13:0] OFFSET_RESET = 14'h0000;
    localparam logic [15:0] MISC_RESET = 16'h0000;

    // Controller software register offsets
    localparam logic [3:0] HREG_CMD = 4'h0;
    localparam logic [3:0] HREG_STATUS = 4'h1;
    localparam logic [3:0] HREG_REF = 4'h2;
    localparam logic [3:0] HREG_RES0 = 4'h3;
    localparam logic [3:0] HREG_RES1 = 4'h4;
    localparam logic [3:0] HREG_GAIN = 4'h5;
    localparam logic [3:0] HREG_OFFSET = 4'h6;
    localparam int STAT_PEND_BIT = 0;
    localparam int STAT_OVR_BIT = 3;
    localparam int STAT_CALERR_BIT = 4;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_SAMPLE = 2'b01,
        ST_MAC = 2'b11,
        ST_ANSWER = 2'b10
    } acm_state_t;

    function automatic logic [7:0] acm_samp_cycles(input logic [1:0] code);
        case (code)
            2'b00: acm_samp_cycles = SAMP_CYC_0;
            2'b01: acm_samp_cycles = SAMP_CYC_1;
            2'b10: acm_samp_cycles = SAMP_CYC_2;
            default: acm_samp_cycles = SAMP_CYC_3;
        endcase
    endfunction

    function automatic logic [31:0] acm_conv_word(input logic sel,
        input logic cal, input logic [3:0] tag, input logic [1:0] sample_time_code,
        input logic [7:0] chan);
        acm_conv_word = '0;
        acm_conv_word[CMD_SEL_BIT] = sel;
        acm_conv_word[CMD_CAL_BIT] = cal;
        acm_conv_word[CMD_TAG_LSB +: TAG_W] = tag;
        acm_conv_word[CMD_LST_LSB +: 2] = sample_time_code;
        acm_conv_word[CMD_CHAN_LSB +: CHAN_W] = chan;
    endfunction

    function automatic logic [31:0] acm_write_word(input logic sel,
        input logic [7:0] addr, input logic [15:0] value);
        acm_write_word = '0;
        acm_write_word[CMD_SEL_BIT] = sel;
        acm_write_word[CMD_VAL_LSB +: REG_W] = value;
        acm_write_word[7:0] = addr;
    endfunction
endpackage

// ### design/acm_link_if.sv
`timescale 1ns/1ps
interface acm_link_if;
    logic cmd_valid;
    logic [31:0] cmd_word;
    logic cmd_ready;
    logic res_valid;
    logic [15:0] res_data;
    logic [3:0] res_tag;
    logic res_engine;

    modport dev (
        input cmd_valid,
        input cmd_word,
        output cmd_ready,
        output res_valid,
        output res_data,
        output res_tag,
        output res_engine
    );

    modport ctl (
        output cmd_valid,
        output cmd_word,
        input cmd_ready,
        input res_valid,
        input res_data,
        input res_tag,
        input res_engine
    );
endinterface

// ### design/acm_mac.sv
`timescale 1ns/1ps
module acm_mac
    import acm_pkg::*;
(
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    // Operands
    input wire logic start,
    input wire logic cal_en,
    input wire logic [11:0] raw,
    input wire logic [14:0] gain,
    input wire logic [13:0] offset,
    // Result
    output logic done,
    output logic [13:0] result
);
    wire [13:0] shifted = {raw, 2'b00}; // see RULE1
    // Full 29-bit product, so no code is lost before scaling
    wire [28:0] prod = {15'h0000, shifted} * {14'h0000, gain}; // see RULE6
    wire [14:0] scaled = prod[28:14];
    wire signed [16:0] sum = $signed({2'b00, scaled})
        + $signed({{3{offset[13]}}, offset}) + HALF_LSB_ADJ; // see RULE7
    wire [13:0] clamped = (sum < 17'sh00000) ? 14'h0000 :
        (sum > RES_MAX) ? 14'h3fff : sum[13:0]; // see RULE14
    wire [13:0] next_result = cal_en ? clamped : shifted; // see RULE4

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            done <= 1'b0;
            result <= 14'h0000;
        end else begin
            done <= start;
            if (start) begin
                result <= next_result;
            end
        end
    end
endmodule // acm_mac

// ### design/acm_engine.sv
// Notes on behaviour
// RULE1 - Raw result shifted left two, 14-bit terms
// RULE2 - Channel 43 high reference, 2-cycle sample
// RULE3 - Channel 44 low reference, 64-cycle sample
// RULE4 - Calibration bit clear returns raw result
// RULE5 - Message tag zero lands in buffer zero
// RULE6 - Gain is unsigned 1.14 fixed point
// RULE7 - Result is raw times gain, plus offset, plus two
// RULE8 - Offset keeps only low 14 bits, signed
// RULE9 - Each engine keeps its own coefficients
// RULE10 - Controller loads coefficients before calibrated conversions
// RULE11 - Write word: value bit 8, address, select bit 25
// RULE12 - Six internal registers, reached only by messages
// RULE13 - Gain bit 15 reserved, integer bit 14, then fraction
// RULE14 - Calibrated result clamps at 14-bit limits
// RULE15 - Reset gives unity gain, zero offset
`timescale 1ns/1ps
module acm_engine
    import acm_pkg::*;
(
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    // Command and result link
    acm_link_if.dev link,
    // Converter front end
    output logic samp_active,
    output logic samp_engine,
    output logic [7:0] samp_channel,
    output logic [1:0] ref_select,
    input wire logic [11:0] samp_data
);
    acm_state_t state;
    logic cmd_ready;
    logic res_valid;
    logic [15:0] res_data;
    logic [3:0] res_tag;
    logic res_engine;
    logic [7:0] samp_count;
    logic cur_sel;
    logic cur_cal;
    logic [3:0] cur_tag;
    logic [11:0] raw_q;
    logic mac_start;
    logic mac_done;
    logic [13:0] mac_result;
    // One coefficient set per engine, never shared
    logic [14:0] gain [ENGINES]; // see RULE9
    logic [13:0] offset [ENGINES]; // see RULE9
    logic [15:0] ctrl_reg [ENGINES];
    logic [15:0] tstamp_reg [ENGINES];
    logic [15:0] tbase_reg [ENGINES];

    assign link.cmd_ready = cmd_ready;
    assign link.res_valid = res_valid;
    assign link.res_data = res_data;
    assign link.res_tag = res_tag;
    assign link.res_engine = res_engine;

    // Command decode
    wire take = link.cmd_valid && cmd_ready;
    wire [7:0] c_addr = link.cmd_word[7:0];
    wire c_sel = link.cmd_word[CMD_SEL_BIT]; // see RULE11
    wire c_flag = link.cmd_word[CMD_CAL_BIT];
    wire [3:0] c_tag = link.cmd_word[CMD_TAG_LSB +: TAG_W];
    wire [1:0] c_lst = link.cmd_word[CMD_LST_LSB +: 2];
    wire [7:0] c_chan = link.cmd_word[CMD_CHAN_LSB +: CHAN_W];
    wire [15:0] c_val = link.cmd_word[CMD_VAL_LSB +: REG_W]; // see RULE11
    wire is_conv = (c_addr == ADDR_CONV);
    wire is_rd = !is_conv && c_flag;
    wire is_wr = !is_conv && !c_flag;
    wire [7:0] samp_len = acm_samp_cycles(c_lst); // see RULE2 RULE3
    wire [1:0] c_ref = (c_chan == CHAN_HIGH_REF) ? REF_SEL_HIGH :
        (c_chan == CHAN_LOW_REF) ? REF_SEL_LOW : REF_SEL_NONE;

    // Register read mux; reserved bits and addresses read zero
    wire [15:0] rd_value =
        (c_addr == ADDR_CTRL) ? ctrl_reg[c_sel] :
        (c_addr == ADDR_TSTAMP) ? tstamp_reg[c_sel] :
        (c_addr == ADDR_TBASE) ? tbase_reg[c_sel] :
        (c_addr == ADDR_GAIN) ? {1'b0, gain[c_sel]} : // see RULE13
        (c_addr == ADDR_OFFSET) ? {2'b00, offset[c_sel]} :
        16'h0000; // see RULE12

    // Internal registers, written only by write messages
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            for (int e = 0; e < ENGINES; e++) begin
                gain[e] <= GAIN_RESET; // see RULE15
                offset[e] <= OFFSET_RESET; // see RULE15
                ctrl_reg[e] <= MISC_RESET;
                tstamp_reg[e] <= MISC_RESET;
                tbase_reg[e] <= MISC_RESET;
            end
        end else if (take && is_wr) begin // see RULE12
            case (c_addr)
                ADDR_CTRL: ctrl_reg[c_sel] <= c_val;
                ADDR_TSTAMP: tstamp_reg[c_sel] <= c_val;
                ADDR_TBASE: tbase_reg[c_sel] <= c_val;
                ADDR_GAIN: gain[c_sel] <= c_val[14:0]; // see RULE13
                // Upper two bits dropped, sign kept in bit 13
                ADDR_OFFSET: offset[c_sel] <= c_val[13:0]; // see RULE8
                default: ;
            endcase
        end
    end

    // Sequencer
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            state <= ST_IDLE;
            cmd_ready <= 1'b1;
            res_valid <= 1'b0;
            res_data <= 16'h0000;
            res_tag <= 4'h0;
            res_engine <= 1'b0;
            samp_active <= 1'b0;
            samp_engine <= 1'b0;
            samp_channel <= 8'h00;
            ref_select <= REF_SEL_NONE;
            samp_count <= 8'h00;
            cur_sel <= 1'b0;
            cur_cal <= 1'b0;
            cur_tag <= 4'h0;
            raw_q <= 12'h000;
            mac_start <= 1'b0;
        end else begin
            case (state)
                ST_IDLE: begin
                    if (take && is_conv) begin
                        cmd_ready <= 1'b0;
                        cur_sel <= c_sel;
                        cur_cal <= c_flag;
                        cur_tag <= c_tag;
                        samp_active <= 1'b1;
                        samp_engine <= c_sel;
                        samp_channel <= c_chan;
                        ref_select <= c_ref; // see RULE2 RULE3
                        samp_count <= 8'(samp_len - 8'h01);
                        state <= ST_SAMPLE;
                    end else if (take && is_rd) begin
                        cmd_ready <= 1'b0;
                        res_valid <= 1'b1;
                        res_data <= rd_value; // see RULE12
                        res_tag <= c_tag;
                        res_engine <= c_sel;
                        state <= ST_ANSWER;
                    end
                end
                ST_SAMPLE: begin
                    if (samp_count == 8'h00) begin
                        samp_active <= 1'b0;
                        ref_select <= REF_SEL_NONE;
                        raw_q <= samp_data;
                        mac_start <= 1'b1;
                        state <= ST_MAC;
                    end else begin
                        samp_count <= 8'(samp_count - 8'h01);
                    end
                end
                ST_MAC: begin
                    mac_start <= 1'b0;
                    if (mac_done) begin
                        res_valid <= 1'b1;
                        res_data <= {2'b00, mac_result};
                        // Tag names the result buffer downstream
                        res_tag <= cur_tag; // see RULE5
                        res_engine <= cur_sel; // see RULE9
                        state <= ST_ANSWER;
                    end
                end
                ST_ANSWER: begin
                    res_valid <= 1'b0;
                    cmd_ready <= 1'b1;
                    state <= ST_IDLE;
                end
                default: begin
                    state <= ST_IDLE;
                    cmd_ready <= 1'b1;
                    res_valid <= 1'b0;
                    samp_active <= 1'b0;
                    mac_start <= 1'b0;
                end
            endcase
        end
    end

    // Coefficients stay put during a conversion: writes only land in idle
    acm_mac i_acm_mac (
        .ref_clk(ref_clk),
        .rst(rst),
        .start(mac_start),
        .cal_en(cur_cal), // see RULE4
        .raw(raw_q),
        .gain(gain[cur_sel]), // see RULE9
        .offset(offset[cur_sel]),
        .done(mac_done),
        .result(mac_result)
    );
endmodule // acm_engine

// ### design/acm_ctrl.sv
`timescale 1ns/1ps
module acm_ctrl
    import acm_pkg::*;
(
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    // Software register port
    input wire logic [3:0] addr,
    input wire logic [31:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [31:0] rdata,
    // Command and result link
    acm_link_if.ctl link
);
    logic cmd_valid;
    logic [31:0] cmd_word;
    logic overrun;
    logic cal_err;
    logic [1:0] gain_loaded;
    logic [1:0] offset_loaded;
    logic [1:0] buf_valid;
    logic [20:0] res_buf [2];

    assign link.cmd_valid = cmd_valid;
    assign link.cmd_word = cmd_word;

    // Build the candidate command for this write
    wire [31:0] ref_word = wdata[1] ?
        acm_conv_word(wdata[0], 1'b0, wdata[7:4], LST_LOW_REF,
            CHAN_LOW_REF) : // see RULE3 RULE4
        acm_conv_word(wdata[0], 1'b0, wdata[7:4], LST_HIGH_REF,
            CHAN_HIGH_REF); // see RULE2 RULE4
    wire [31:0] new_word =
        (addr == HREG_REF) ? ref_word :
        (addr == HREG_GAIN) ? acm_write_word(wdata[16], ADDR_GAIN,
            wdata[15:0]) : // see RULE11
        (addr == HREG_OFFSET) ? acm_write_word(wdata[16], ADDR_OFFSET,
            wdata[15:0]) : wdata;
    wire is_cmd = (addr == HREG_CMD) || (addr == HREG_REF)
        || (addr == HREG_GAIN) || (addr == HREG_OFFSET);
    wire n_sel = new_word[CMD_SEL_BIT];
    wire n_cal_conv = (new_word[7:0] == ADDR_CONV) && new_word[CMD_CAL_BIT];
    // Calibrated conversions are refused until both coefficients went out
    wire n_unready = n_cal_conv
        && !(gain_loaded[n_sel] && offset_loaded[n_sel]); // see RULE10
    wire issue_req = wr && is_cmd;
    wire busy = cmd_valid;
    wire issue = issue_req && !busy && !n_unready;
    wire taken = cmd_valid && link.cmd_ready;
    wire t_sel = cmd_word[CMD_SEL_BIT];
    wire t_gain = taken && (cmd_word[7:0] == ADDR_GAIN)
        && !cmd_word[CMD_RD_BIT];
    wire t_off = taken && (cmd_word[7:0] == ADDR_OFFSET)
        && !cmd_word[CMD_RD_BIT];
    wire res_slot = link.res_tag[0]; // see RULE5
    wire clr_st = wr && (addr == HREG_STATUS);
    wire rd0 = rd && (addr == HREG_RES0);
    wire rd1 = rd && (addr == HREG_RES1);
    wire [31:0] status_word = {27'h0000000, cal_err, overrun, buf_valid,
        cmd_valid};
    wire [31:0] next_rdata =
        !rd ? 32'h00000000 :
        (addr == HREG_CMD) ? cmd_word :
        (addr == HREG_STATUS) ? status_word :
        (addr == HREG_RES0) ? {11'h000, res_buf[0]} :
        (addr == HREG_RES1) ? {11'h000, res_buf[1]} : 32'h00000000;

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            cmd_valid <= 1'b0;
            cmd_word <= 32'h00000000;
            rdata <= 32'h00000000;
        end else begin
            rdata <= next_rdata;
            if (issue) begin
                cmd_valid <= 1'b1;
                cmd_word <= new_word;
            end else if (taken) begin
                cmd_valid <= 1'b0;
            end
        end
    end

    // Sticky flags: a new event wins over a same-cycle clear
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            overrun <= 1'b0;
            cal_err <= 1'b0;
            gain_loaded <= 2'b00;
            offset_loaded <= 2'b00;
        end else begin
            overrun <= (issue_req && busy)
                || (overrun && !(clr_st && wdata[STAT_OVR_BIT]));
            cal_err <= (issue_req && !busy && n_unready)
                || (cal_err && !(clr_st && wdata[STAT_CALERR_BIT]));
            if (t_gain) begin
                gain_loaded[t_sel] <= 1'b1; // see RULE10
            end
            if (t_off) begin
                offset_loaded[t_sel] <= 1'b1; // see RULE10
            end
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            buf_valid <= 2'b00;
            res_buf[0] <= 21'h000000;
            res_buf[1] <= 21'h000000;
        end else begin
            buf_valid[0] <= (link.res_valid && !res_slot)
                || (buf_valid[0] && !rd0);
            buf_valid[1] <= (link.res_valid && res_slot)
                || (buf_valid[1] && !rd1);
            if (link.res_valid) begin
                res_buf[res_slot] <= {link.res_engine, link.res_tag,
                    link.res_data};
            end
        end
    end
endmodule // acm_ctrl

// ### dv/acm_link_properties.sv
`timescale 1ns/1ps
module acm_link_properties (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    // Link signals
    input wire logic cmd_valid,
    input wire logic [31:0] cmd_word,
    input wire logic cmd_ready,
    input wire logic res_valid,
    input wire logic [15:0] res_data,
    input wire logic [3:0] res_tag,
    input wire logic res_engine
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (rst);
    wire take = cmd_valid && cmd_ready;
    wire is_conv = cmd_word[7:0] == 8'h00;
    wire is_rd = !is_conv && cmd_word[24];
    wire answered = take && (is_conv || is_rd);
    // Last answered word, what the next answer must echo
    logic [31:0] last_word;
    wire last_rd = last_word[7:0] != 8'h00 && last_word[24];
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst)
            last_word <= 32'h0;
        else if (answered)
            last_word <= cmd_word;
    end
    // Coefficients as last written, per engine, for readback and loading
    wire wr_take = take && !is_conv && !is_rd;
    wire w_sel = cmd_word[25];
    logic [14:0] gain_seen [2];
    logic [13:0] off_seen [2];
    logic [1:0] g_ld;
    logic [1:0] o_ld;
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            gain_seen[0] <= 15'h4000;
            gain_seen[1] <= 15'h4000;
            off_seen[0] <= 14'h0;
            off_seen[1] <= 14'h0;
            g_ld <= 2'h0;
            o_ld <= 2'h0;
        end else if (wr_take && cmd_word[7:0] == 8'h04) begin
            gain_seen[w_sel] <= cmd_word[22:8];
            g_ld[w_sel] <= 1'h1;
        end else if (wr_take && cmd_word[7:0] == 8'h05) begin
            off_seen[w_sel] <= cmd_word[21:8];
            o_ld[w_sel] <= 1'h1;
        end
    end
    property p_write_quiet;
        take && !is_conv && !is_rd |=> cmd_ready && !res_valid;
    endproperty
    property p_read_answer;
        take && is_rd |=> res_valid;
    endproperty
    property p_busy;
        answered |=> !cmd_ready;
    endproperty
    // Answer is sampled S + 3 edges after the take
    property p_high_time;
        take && is_conv && cmd_word[19:18] == 2'h0
            |=> !res_valid [*4] ##1 res_valid;
    endproperty
    property p_low_time;
        take && is_conv && cmd_word[19:18] == 2'h2
            |=> !cmd_ready [*8] ##59 res_valid;
    endproperty
    property p_pulse;
        res_valid |=> !res_valid && cmd_ready;
    endproperty
    property p_tag_echo;
        res_valid |-> res_tag == last_word[23:20];
    endproperty
    property p_engine_echo;
        res_valid |-> res_engine == last_word[25];
    endproperty
    property p_raw;
        res_valid && last_word[7:0] == 8'h00 && !last_word[24]
            |-> res_data[15:14] == 2'h0 && res_data[1:0] == 2'h0;
    endproperty
    property p_offset_rd;
        res_valid && last_rd && last_word[7:0] == 8'h05
            |-> res_data == {2'h0, off_seen[last_word[25]]};
    endproperty
    property p_gain_rd;
        res_valid && last_rd && last_word[7:0] == 8'h04
            |-> res_data == {1'h0, gain_seen[last_word[25]]};
    endproperty
    property p_req_hold;
        cmd_valid && !cmd_ready |=> cmd_valid && $stable(cmd_word);
    endproperty
    property p_cal_loaded;
        take && is_conv && cmd_word[24]
            |-> g_ld[cmd_word[25]] && o_ld[cmd_word[25]];
    endproperty
    a_write_quiet: assert property (p_write_quiet)
        else $error("write got an answer or stalled the link");
    a_read_answer: assert property (p_read_answer)
        else $error("read not answered next cycle");
    a_busy: assert property (p_busy)
        else $error("ready stayed high after a taken request");
    a_high_time: assert property (p_high_time)
        else $error("short sample conversion answered at wrong time");
    a_low_time: assert property (p_low_time)
        else $error("long sample conversion answered at wrong time");
    a_pulse: assert property (p_pulse)
        else $error("answer not a single pulse followed by ready");
    a_tag_echo: assert property (p_tag_echo)
        else $error("answer tag differs from request tag");
    a_engine_echo: assert property (p_engine_echo)
        else $error("answer engine differs from request engine");
    a_raw: assert property (p_raw)
        else $error("uncorrected result not a shifted 12-bit code");
    a_offset_rd: assert property (p_offset_rd)
        else $error("offset readback differs from last write");
    a_gain_rd: assert property (p_gain_rd)
        else $error("gain readback differs from last write");
    a_req_hold: assert property (p_req_hold)
        else $error("pending request dropped or changed before taken");
    a_cal_loaded: assert property (p_cal_loaded)
        else $error("calibrated conversion sent before coefficients");
    c_cal_conv: cover property (take && is_conv && cmd_word[24]);
    c_read: cover property (res_valid && last_rd);
    c_long: cover property (take && is_conv && cmd_word[19:18] == 2'h2);
    c_queued: cover property (cmd_valid && !cmd_ready);
endmodule // acm_link_properties

// ### dv/acm_bench.sv
`timescale 1ns/1ps
module acm_bench;
    import acm_pkg::*;
    logic ref_clk, rst, wr, rd, samp_active, samp_engine;
    logic [3:0] addr;
    logic [31:0] wdata, rdata, s;
    logic [11:0] samp_data;
    logic [7:0] samp_channel;
    logic [1:0] ref_select;
    int err_count, checked;
    acm_link_if link();
    acm_ctrl i_acm_ctrl (.ref_clk, .rst, .addr, .wdata, .wr, .rd, .rdata,
        .link);
    acm_engine i_acm_engine (.ref_clk, .rst, .link, .samp_active,
        .samp_engine, .samp_channel, .ref_select, .samp_data);
    acm_link_properties i_acm_link_properties (.ref_clk, .rst,
        .cmd_valid(link.cmd_valid), .cmd_word(link.cmd_word),
        .cmd_ready(link.cmd_ready), .res_valid(link.res_valid),
        .res_data(link.res_data), .res_tag(link.res_tag),
        .res_engine(link.res_engine));
    initial begin
        ref_clk = 1'h0;
        forever #12.5 ref_clk = ~ref_clk;
    end
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", checked, err_count);
        if (err_count == 0 && checked > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    task automatic time_out();
        err_count++;
        $display("mismatch wait expected done seen timeout");
        give_verdict();
    endtask
    task automatic chk(input string what, input logic [31:0] exp,
        input logic [31:0] got);
        checked++;
        if (got !== exp) begin
            err_count++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic sw_wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        addr <= a;
        wdata <= d;
        wr <= 1'h1;
        @(posedge ref_clk);
        wr <= 1'h0;
    endtask
    task automatic sw_rd(input logic [3:0] a, output logic [31:0] d);
        @(posedge ref_clk);
        addr <= a;
        rd <= 1'h1;
        @(posedge ref_clk);
        rd <= 1'h0;
        #1 d = rdata;
    endtask
    // Polls the buffer flag; a stuck engine ends the run
    task automatic get_res(input int b, output logic [31:0] d);
        logic [31:0] st;
        st = 32'h0;
        for (int n = 0; n < 200 && st[b + 1] !== 1'h1; n++)
            sw_rd(HREG_STATUS, st);
        if (st[b + 1] !== 1'h1)
            time_out();
        sw_rd(b ? HREG_RES1 : HREG_RES0, d);
    endtask
    task automatic reg_chk(input logic e, input logic [7:0] a,
        input logic [3:0] t, input logic [15:0] exp);
        sw_wr(HREG_CMD, {6'h0, e, 1'h1, t, 12'h0, a});
        get_res(t[0], s);
        chk("readback", {11'h0, e, t, exp}, s);
    endtask
    function automatic logic [15:0] cal_exp(input logic [11:0] raw,
        input int g, input int o);
        int v;
        v = ((int'(raw) * 4 * g) >> 14) + o + 2;
        if (v < 0)
            v = 0;
        if (v > 16383)
            v = 16383;
        return v[15:0];
    endfunction
    task automatic t_reset();
        sw_rd(HREG_STATUS, s);
        chk("status", 32'h0, s);
        reg_chk(1'h0, ADDR_GAIN, 4'h0, 16'h4000);
        reg_chk(1'h1, ADDR_OFFSET, 4'h1, 16'h0);
        reg_chk(1'h0, 8'h06, 4'h2, 16'h0);
        sw_rd(4'h7, s);
        chk("unmapped", 32'h0, s);
    endtask
    task automatic t_refs();
        int n;
        for (int i = 0; i < 2; i++) begin
            @(posedge ref_clk);
            samp_data <= i ? 12'h40d : 12'hbf9;
            sw_wr(HREG_REF, i ? 32'h3 : 32'h0);
            for (n = 0; n < 20 && samp_active !== 1'h1; n++) begin
                @(posedge ref_clk);
                #1;
            end
            if (n == 20)
                time_out();
            chk("ref_select", i ? REF_SEL_LOW : REF_SEL_HIGH,
                ref_select);
            chk("channel", i ? CHAN_LOW_REF : CHAN_HIGH_REF,
                samp_channel);
            chk("samp_engine", i, samp_engine);
            for (n = 0; n < 200 && samp_active === 1'h1; n++) begin
                @(posedge ref_clk);
                #1;
            end
            chk("sample cycles", i ? 64 : 2, n);
            get_res(0, s);
            chk("raw result", {11'h0, i[0], 6'h0, i ? 12'h40d : 12'hbf9,
                2'h0}, s);
        end
    endtask
    task automatic t_cal();
        logic [11:0] raws [4] = '{12'hbf9, 12'hfff, 12'h000, 12'h123};
        logic e;
        // Calibrated request before coefficients exist is dropped
        sw_wr(HREG_CMD, {6'h0, 1'h0, 1'h1, 16'h0005, 8'h0});
        sw_rd(HREG_STATUS, s);
        chk("cal_err", 32'h10, s & 32'h12);
        sw_wr(HREG_STATUS, 32'h18);
        sw_wr(HREG_GAIN, 32'h0000c04c);
        sw_wr(HREG_OFFSET, 32'h0000ffde);
        sw_wr(HREG_GAIN, 32'h00014000);
        sw_wr(HREG_OFFSET, 32'h00010005);
        reg_chk(1'h0, ADDR_GAIN, 4'h0, 16'h404c);
        reg_chk(1'h0, ADDR_OFFSET, 4'h1, 16'h3fde);
        for (int i = 0; i < 4; i++) begin
            e = i == 3;
            @(posedge ref_clk);
            samp_data <= raws[i];
            sw_wr(HREG_CMD, {6'h0, e, 1'h1, i[3:0], i[1:0], 10'h005, 8'h0});
            get_res(i % 2, s);
            chk("cal result", {11'h0, e, i[3:0], cal_exp(raws[i],
                e ? 16384 : 16460, e ? 5 : -34)}, s);
        end
    endtask
    task automatic t_busy();
        // Read queued behind a long conversion, third write refused
        sw_wr(HREG_CMD, 32'h00080500);
        sw_wr(HREG_CMD, {6'h0, 1'h0, 1'h1, 4'h1, 12'h0, ADDR_GAIN});
        sw_wr(HREG_CMD, 32'h0);
        sw_rd(HREG_STATUS, s);
        chk("overrun", 32'h9, s & 32'h9);
        get_res(0, s);
        chk("raw result", {18'h0, samp_data, 2'h0}, s);
        get_res(1, s);
        chk("queued read", {16'h1, 16'h404c}, s);
    endtask
    initial begin
        rst = 1'h1;
        wr = 1'h0;
        rd = 1'h0;
        addr = 4'h0;
        wdata = 32'h0;
        samp_data = 12'h0;
        err_count = 0;
        checked = 0;
        repeat (5) @(posedge ref_clk);
        rst <= 1'h0;
        t_reset();
        t_refs();
        t_cal();
        t_busy();
        give_verdict();
    end
endmodule // acm_bench
